// ===== src/mb_rw_params.svh
// Purpose: constants for the multi-register write and read/write request handler
// Assumes: one clock, synchronous active-high reset
// Notes:   offsets, codes and counts only; types live in mb_rw_pkg
//
// Functional notes
// RULE_01: function 0x10 stores values into consecutive holding registers from start address.
// RULE_02: client sends function, start, count, byte count, then two bytes per register.
// RULE_03: register count is at least one; the maximum is a parameter.
// RULE_04: successful 0x10 reply is function, start address and count written.
// RULE_05: function 0x17 does one block write and one block read per transaction.
// RULE_06: every 0x17 write completes before any register is read back.
// RULE_07: register addresses are zero based; register n travels as n-1.
// RULE_08: 0x17 request carries read start and read count first.
// RULE_09: then write start, write count, byte count and the write data.
// RULE_10: 0x17 reply is function, byte count twice read count, then read data.
// RULE_11: failure reply is 0x90 or 0x97 followed by one exception code. Any other function code is answered as that code with 0x80 set, then code 01.
// RULE_12: each 16-bit value travels high byte first, low byte second.
// RULE_13: frames ride as TCP application data units on port 502.
// RULE_14: bad count or byte count gives exception 03 and writes nothing.
`ifndef MB_RW_PARAMS_SVH
`define MB_RW_PARAMS_SVH

`define FC_WR_MULTI    8'h10
`define FC_RW_MULTI    8'h17
`define FC_ERR_FLAG    8'h80
`define EXC_NONE       8'h00
`define EXC_BAD_FUNC   8'h01
`define EXC_BAD_ADDR   8'h02
`define EXC_BAD_VALUE  8'h03
`define HDR_LAST_WR    4'h4
`define HDR_LAST_RW    4'h8
`define MAX_WR_REGS    16'h0078
`define MAX_RD_REGS    16'h0076
`define RESP_LEN_WR    8'h05
`define RESP_LEN_EXC   8'h02
`define RESP_DATA_OFS  8'h02
`define TCP_PORT       16'h01F6
`define RST_BYTE       8'h00

`endif

// ===== src/mb_rw_pkg.sv
// Purpose: shared types of the request handler
// Assumes: included alongside mb_rw_params.svh
// Notes:   byte streams carry data with an end-of-frame flag
package mb_rw_pkg;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } pdu_beat_s;

  typedef logic [15:0] reg_word_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_HDR   = 3'b001,
    S_DATA  = 3'b010,
    S_DRAIN = 3'b011,
    S_TX    = 3'b100
  } state_e;

endpackage

// ===== src/holding_reg_bank.sv
// Purpose: holding register array, one write port and one combinational read port
// Assumes: addresses already range-checked by the caller
// Notes:   contents are not reset, as a real register image would be loaded by software
`timescale 1ns/1ns
module holding_reg_bank #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  wr_en_i,
  input  wire logic [AW-1:0]         wr_addr_i,
  input  wire mb_rw_pkg::reg_word_t  wr_data_i,
  input  wire logic [AW-1:0]         rd_addr_i,
  output mb_rw_pkg::reg_word_t       rd_data_o
);
  import mb_rw_pkg::*;

  reg_word_t mem [DEPTH];

  // address n in the frame is array index n, no offset applied [RULE_07]
  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  assign rd_data_o = mem[rd_addr_i];

endmodule

// ===== src/mb_rw_engine.sv
// Purpose: request handler for write-multiple (0x10) and read/write-multiple (0x17)
// Assumes: request PDU bytes arrive stripped of the TCP application header
// Notes:   response goes out as a PDU byte stream for the transport to wrap
`timescale 1ns/1ns
`include "mb_rw_params.svh"
module mb_rw_engine #(
  parameter int          DEPTH   = 256,
  parameter logic [15:0] MAX_WR  = `MAX_WR_REGS,
  parameter logic [15:0] MAX_RD  = `MAX_RD_REGS
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 sys_rst_i,
  input  wire mb_rw_pkg::pdu_beat_s rx_beat_i,
  input  wire logic                 rx_valid_i,
  output logic                      rx_ready_o,
  output mb_rw_pkg::pdu_beat_s      tx_beat_o,
  output logic                      tx_valid_o,
  input  wire logic                 tx_ready_i
);
  import mb_rw_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [16:0] DEPTH17 = 17'(DEPTH);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  state_e      state_q;
  state_e      state_d;
  logic [7:0]  func_q;
  logic [63:0] hdr_q;
  logic [3:0]  hdr_cnt_q;
  logic [7:0]  bc_q;
  logic [7:0]  data_cnt_q;
  logic [7:0]  hi_q;
  logic [7:0]  exc_q;
  logic [7:0]  tx_idx_q;
  pdu_beat_s   tx_q;
  logic        tx_valid_q;
  logic        rx_ready_q;

  // ------------------------------------------------------------
  // request decode
  // ------------------------------------------------------------
  // bytes are the PDU of a TCP application unit on port 502, unwrapped outside [RULE_13]
  wire        rx_take   = rx_valid_i && rx_ready_q;
  wire        is_rw     = (func_q == `FC_RW_MULTI);
  // read part sits ahead of write part in the 0x17 header [RULE_08] [RULE_09]
  wire [15:0] rd_start  = hdr_q[63:48];
  wire [15:0] rd_cnt    = hdr_q[47:32];
  wire [15:0] wr_start  = hdr_q[31:16];
  wire [15:0] wr_cnt    = hdr_q[15:0];
  wire [3:0]  hdr_last  = is_rw ? `HDR_LAST_RW : `HDR_LAST_WR;
  wire        hdr_done  = (state_q == S_HDR) && rx_take && (hdr_cnt_q == hdr_last);
  wire        func_ok   = (rx_beat_i.data == `FC_WR_MULTI) || (rx_beat_i.data == `FC_RW_MULTI);

  // count limits and byte-count consistency [RULE_03] [RULE_02]
  wire        w_qty_ok  = (wr_cnt != 16'h0000) && (wr_cnt <= MAX_WR)
                          && ({8'h00, rx_beat_i.data} == {wr_cnt[14:0], 1'b0});
  wire        r_qty_ok  = !is_rw || ((rd_cnt != 16'h0000) && (rd_cnt <= MAX_RD));
  wire [16:0] w_end     = {1'b0, wr_start} + {1'b0, wr_cnt};
  wire [16:0] r_end     = {1'b0, rd_start} + {1'b0, rd_cnt};
  wire        addr_ok   = (w_end <= DEPTH17) && (!is_rw || (r_end <= DEPTH17));
  // quantity errors take priority over address errors [RULE_14]
  wire [7:0]  hdr_exc   = !(w_qty_ok && r_qty_ok) ? `EXC_BAD_VALUE :
                          !addr_ok ? `EXC_BAD_ADDR : `EXC_NONE;

  // ------------------------------------------------------------
  // register write path
  // ------------------------------------------------------------
  wire        data_take = (state_q == S_DATA) && rx_take;
  // second byte of each pair completes a word, high byte came first [RULE_12]
  wire        wr_en     = data_take && data_cnt_q[0];
  wire [15:0] wr_addr   = wr_start + {9'h000, data_cnt_q[7:1]};
  wire [15:0] wr_data   = {hi_q, rx_beat_i.data};
  wire        data_end  = data_take && (data_cnt_q == bc_q - 8'h01);

  // ------------------------------------------------------------
  // response path
  // ------------------------------------------------------------
  wire        has_exc   = (exc_q != `EXC_NONE);
  wire [7:0]  rd_bytes  = {rd_cnt[6:0], 1'b0};
  wire [7:0]  resp_len  = has_exc ? `RESP_LEN_EXC :
                          is_rw ? (`RESP_DATA_OFS + rd_bytes) : `RESP_LEN_WR;
  wire        tx_slot   = (state_q == S_TX) && (!tx_valid_q || tx_ready_i);
  wire        tx_load   = tx_slot && (tx_idx_q < resp_len);
  wire        tx_end    = tx_slot && (tx_idx_q == resp_len);
  wire [7:0]  rd_ofs    = tx_idx_q - `RESP_DATA_OFS;
  // reading only happens in S_TX, after every write of the frame [RULE_06]
  wire [15:0] rd_addr   = rd_start + {9'h000, rd_ofs[7:1]};
  reg_word_t  rd_data;
  wire [7:0]  wr_byte   = (tx_idx_q == 8'h01) ? wr_start[15:8] :
                          (tx_idx_q == 8'h02) ? wr_start[7:0] :
                          (tx_idx_q == 8'h03) ? wr_cnt[15:8] : wr_cnt[7:0];
  // even data index is the high byte of a word [RULE_12]
  wire [7:0]  rw_byte   = (tx_idx_q == 8'h01) ? rd_bytes :
                          rd_ofs[0] ? rd_data[7:0] : rd_data[15:8];
  // exception answer: flagged function then one code [RULE_11]
  wire [7:0]  tx_byte   = (tx_idx_q == 8'h00) ? (has_exc ? (func_q | `FC_ERR_FLAG) : func_q) :
                          has_exc ? exc_q :
                          is_rw ? rw_byte : wr_byte;   // [RULE_04] [RULE_10]

  holding_reg_bank #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_bank (
    .core_clk_i (core_clk_i),
    .wr_en_i    (wr_en),
    .wr_addr_i  (wr_addr[AW-1:0]),   // [RULE_07] [RULE_01]
    .wr_data_i  (wr_data),
    .rd_addr_i  (rd_addr[AW-1:0]),
    .rd_data_o  (rd_data)
  );

  // ------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (rx_take) begin
          if (rx_beat_i.last) begin
            state_d = S_TX;
          end else if (func_ok) begin
            state_d = S_HDR;
          end else begin
            state_d = S_DRAIN;
          end
        end
      end
      S_HDR: begin
        if (hdr_done && (hdr_exc == `EXC_NONE) && !rx_beat_i.last) begin
          state_d = S_DATA;
        end else if (hdr_done && !rx_beat_i.last) begin
          state_d = S_DRAIN;
        end else if (rx_take && rx_beat_i.last) begin
          state_d = S_TX;
        end
      end
      S_DATA: begin
        if (data_take && rx_beat_i.last) begin
          state_d = S_TX;
        end else if (data_end) begin
          state_d = S_DRAIN;
        end
      end
      S_DRAIN: begin
        if (rx_take && rx_beat_i.last) begin
          state_d = S_TX;
        end
      end
      S_TX: begin
        if (tx_end) begin
          state_d = S_IDLE;   // one answer per frame, then the next frame [RULE_05]
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  wire rx_ready_d = (state_d != S_TX);

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_q    <= S_IDLE;
      rx_ready_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      rx_ready_q <= rx_ready_d;
    end
  end

  // header capture; bad function answers exception 01
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      func_q    <= `RST_BYTE;
      hdr_q     <= 64'h0000_0000_0000_0000;
      hdr_cnt_q <= 4'h0;
      bc_q      <= `RST_BYTE;
      exc_q     <= `EXC_NONE;
    end else if ((state_q == S_IDLE) && rx_take) begin
      func_q    <= rx_beat_i.data;
      hdr_q     <= 64'h0000_0000_0000_0000;
      hdr_cnt_q <= 4'h0;
      exc_q     <= !func_ok ? `EXC_BAD_FUNC :
                   rx_beat_i.last ? `EXC_BAD_VALUE : `EXC_NONE;   // [RULE_11]
    end else if (hdr_done) begin
      bc_q  <= rx_beat_i.data;
      exc_q <= rx_beat_i.last ? `EXC_BAD_VALUE : hdr_exc;       // [RULE_14]
    end else if ((state_q == S_HDR) && rx_take) begin
      hdr_q     <= {hdr_q[55:0], rx_beat_i.data};
      hdr_cnt_q <= hdr_cnt_q + 4'h1;
      exc_q     <= rx_beat_i.last ? `EXC_BAD_VALUE : `EXC_NONE;
    end else if (data_take && rx_beat_i.last && !data_end) begin
      // short frame: words already stored stay, the client is told 03
      exc_q <= `EXC_BAD_VALUE;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      data_cnt_q <= `RST_BYTE;
      hi_q       <= `RST_BYTE;
    end else if (hdr_done) begin
      data_cnt_q <= `RST_BYTE;
    end else if (data_take) begin
      data_cnt_q <= data_cnt_q + 8'h01;
      hi_q       <= rx_beat_i.data;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tx_idx_q   <= `RST_BYTE;
      tx_q       <= '0;
      tx_valid_q <= 1'b0;
    end else if (tx_load) begin
      tx_idx_q   <= tx_idx_q + 8'h01;
      tx_q       <= '{data: tx_byte, last: (tx_idx_q == resp_len - 8'h01)};
      tx_valid_q <= 1'b1;
    end else if (tx_end) begin
      tx_idx_q   <= `RST_BYTE;
      tx_valid_q <= 1'b0;
    end
  end

  assign rx_ready_o = rx_ready_q;
  assign tx_beat_o  = tx_q;
  assign tx_valid_o = tx_valid_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_write_gated:  assert property (wr_en |-> exc_q == `EXC_NONE && bc_q != 8'h00) // [RULE_14]
    else $error("register written while request flagged bad");
  chk_write_bounds: assert property (wr_en |-> ({1'b0, wr_addr} < w_end)) // [RULE_01]
    else $error("write outside requested block");
  chk_count_min:    assert property ((state_q == S_DATA) |-> wr_cnt != 16'h0000) // [RULE_03]
    else $error("data phase with zero register count");
  chk_pair_odd:     assert property (wr_en |-> !$past(wr_en)) // [RULE_12]
    else $error("two words written on consecutive bytes");
  chk_no_write_tx:  assert property ((state_q == S_TX) |-> !wr_en && !rx_ready_q) // [RULE_06]
    else $error("write or intake during response");
  chk_wr_len:       assert property (tx_valid_q && tx_q.last && !has_exc && !is_rw // [RULE_04]
                                     |-> tx_idx_q == 8'h05 && tx_q.data == wr_cnt[7:0])
    else $error("write reply length wrong");
  chk_rw_count:     assert property (tx_load && tx_idx_q == 8'h01 && !has_exc && is_rw
                                     |=> tx_q.data == {rd_cnt[6:0], 1'b0}) // [RULE_10]
    else $error("read byte count wrong");
  chk_exc_func:     assert property (tx_load && tx_idx_q == 8'h00 && has_exc
                                     |=> tx_q.data[7] && tx_q.data[6:0] == func_q[6:0]) // [RULE_11]
    else $error("exception reply lacks error flag");
  chk_exc_code:     assert property (has_exc |-> exc_q inside {8'h01, 8'h02, 8'h03}) // [RULE_11]
    else $error("exception code out of range");
  chk_one_frame:    assert property (tx_valid_q && tx_q.last && tx_ready_i // [RULE_05]
                                     |=> !tx_valid_q && state_q == S_IDLE)
    else $error("response continued past its last byte");

  cov_wr_ok:  cover property (tx_load && !has_exc && !is_rw && tx_idx_q == 8'h04);
  cov_rw_ok:  cover property (tx_load && !has_exc && is_rw && tx_idx_q == 8'h05);
  cov_exc:    cover property (tx_load && has_exc && tx_idx_q == 8'h01);

endmodule

// ===== sim/mb_client_model.sv
// Purpose: client side of the request handler: sends a request, gathers the answer
// Assumes: one frame at a time, bytes offered just after a rising edge
// Notes:   slow mode toggles tx acceptance each cycle to stall the answer
`timescale 1ns/1ns
module mb_client_model (
  input  wire logic                 core_clk_i,
  input  wire logic                 rx_ready_i,
  input  wire mb_rw_pkg::pdu_beat_s tx_beat_i,
  input  wire logic                 tx_valid_i,
  output mb_rw_pkg::pdu_beat_s      beat_o,
  output logic                      valid_o,
  output logic                      ready_o
);
  import mb_rw_pkg::*;

  initial begin
    beat_o = '0;
    valid_o = 1'b0;
    ready_o = 1'b1;
  end

  // byte order of the frame is built by the caller
  task automatic xfer(input logic [7:0] req[$], input bit slow, output logic [7:0] rsp[$]);
    int i;
    bit done;
    i = 0;
    done = 1'b0;
    rsp = {};
    @(posedge core_clk_i);
    beat_o <= {req[0], req.size() == 1};
    valid_o <= 1'b1;
    while (i < req.size()) begin
      @(posedge core_clk_i);
      if (rx_ready_i) begin
        i++;
        if (i < req.size()) beat_o <= {req[i], i == req.size() - 1};
      end
    end
    valid_o <= 1'b0;
    // released line must not keep showing the last byte
    beat_o <= {~req[i-1], 1'b0};
    while (!done) begin
      @(posedge core_clk_i);
      if (tx_valid_i && ready_o) begin
        rsp.push_back(tx_beat_i.data);
        done = tx_beat_i.last;
      end
      ready_o <= (slow && !done) ? ~ready_o : 1'b1;
    end
  endtask
endmodule

// ===== sim/modbus_multi_register_write_rw_tb.sv
// Purpose: self-checking bench for the write and read/write request handler
// Assumes: default DEPTH of 256 registers and default count limits
// Notes:   register image is not reset, so reads only touch written words
`timescale 1ns/1ns
module modbus_multi_register_write_rw_tb;
  import mb_rw_pkg::*;
  typedef logic [7:0] bq_t[$];

  logic      core_clk_i;
  logic      sys_rst_i;
  pdu_beat_s rx_beat;
  pdu_beat_s tx_beat;
  logic      rx_valid;
  logic      rx_ready;
  logic      tx_valid;
  logic      tx_ready;
  int        error_cnt;
  int        checked;
  int        cyc;

  initial core_clk_i = 1'b0;
  always #20 core_clk_i = ~core_clk_i;

  mb_rw_engine u_mb_rw_engine (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .rx_beat_i(rx_beat),
    .rx_valid_i(rx_valid), .rx_ready_o(rx_ready), .tx_beat_o(tx_beat),
    .tx_valid_o(tx_valid), .tx_ready_i(tx_ready));

  mb_client_model u_mb_client_model (
    .core_clk_i(core_clk_i), .rx_ready_i(rx_ready), .tx_beat_i(tx_beat),
    .tx_valid_i(tx_valid), .beat_o(rx_beat), .valid_o(rx_valid), .ready_o(tx_ready));

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  function automatic bq_t bq(input logic [191:0] v, input int n);
    bq_t q;
    for (int i = 0; i < n; i++) q.push_back(v[8*(n-1-i) +: 8]);
    return q;
  endfunction

  task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmp_len(input string name, input int exp, input int got);
    checked++;
    if (got != exp) begin
      error_cnt++;
      $display("wrong value %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic run(input string name, input bq_t req, input bq_t exp, input bit slow);
    bq_t rsp;
    u_mb_client_model.xfer(req, slow, rsp);
    cmp_len({name, " length"}, exp.size(), rsp.size());
    foreach (exp[k]) if (k < rsp.size()) cmp8(name, exp[k], rsp[k]);
    repeat (2) @(posedge core_clk_i);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_write_multi();
    run("wr3", bq(96'h10_0003_0003_06_04CE_FFC0_1234, 12),
        bq(40'h10_0003_0003, 5), 1'b0);
    run("wr_top", bq(80'h10_00FE_0002_04_1111_2222, 10),
        bq(40'h10_00FE_0002, 5), 1'b0);
    // bytes after the data block are ignored, the answer stays normal
    run("extra", bq(72'h10_0010_0001_02_2468_99, 9),
        bq(40'h10_0010_0001, 5), 1'b0);
    $display("test write_multi done");
  endtask

  task automatic t_read_write();
    // write lands on register 5 inside the read range, answer stalled
    run("rw", bq(96'h17_0003_0003_0005_0001_02_ABCD, 12),
        bq(64'h17_06_04CE_FFC0_ABCD, 8), 1'b1);
    $display("test read_write done");
  endtask

  task automatic t_bad_counts();
    // data bytes follow each bad count header, so only the count check can refuse it; hdr_short ends inside the header
    run("cnt0", bq(64'h10_0003_0000_00_1111, 8), bq(16'h9003, 2), 1'b0);
    run("cntmax", bq(64'h10_0003_0079_F2_1111, 8), bq(16'h9003, 2), 1'b0);
    run("bytecnt", bq(64'h10_0004_0001_04_5566, 8), bq(16'h9003, 2), 1'b0);
    run("rdcnt0", bq(96'h17_0003_0000_0004_0001_02_7788, 12),
        bq(16'h9703, 2), 1'b0);
    run("hdr_short", bq(32'h10_0003_00, 4), bq(16'h9003, 2), 1'b0);
    // a frame cut inside the data keeps the word already stored
    run("data_short", bq(72'h10_0006_0002_04_1357_24, 9), bq(16'h9003, 2), 1'b0);
    run("kept", bq(96'h17_0006_0001_00FE_0001_02_0000, 12),
        bq(32'h17_02_1357, 4), 1'b0);
    $display("test bad_counts done");
  endtask

  task automatic t_bad_func_addr();
    run("func", bq(8'h05, 1), bq(16'h8501, 2), 1'b0);
    run("func_long", bq(40'h03_0000_0001, 5), bq(16'h8301, 2), 1'b0);
    run("wr_range", bq(80'h10_00FF_0002_04_1122_3344, 10),
        bq(16'h9002, 2), 1'b0);
    run("rd_range", bq(96'h17_00FF_0002_0003_0001_02_9999, 12),
        bq(16'h9702, 2), 1'b0);
    $display("test bad_func_addr done");
  endtask

  task automatic t_no_side_effect();
    // refused frames above must have left registers 3 to 5 untouched
    run("intact", bq(96'h17_0003_0003_00FE_0001_02_5A5A, 12),
        bq(64'h17_06_04CE_FFC0_ABCD, 8), 1'b0);
    $display("test no_side_effect done");
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // all frames are short, so a few thousand cycles is ample
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial begin
    error_cnt = 0;
    checked = 0;
    cyc = 0;
    sys_rst_i = 1'b1;
    repeat (2) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    t_write_multi();
    t_read_write();
    t_bad_counts();
    t_bad_func_addr();
    t_no_side_effect();
    tally_and_finish();
  end
endmodule
